// ===== design/ocr_regs.sv
// Output configuration register pair with its output routing
`timescale 1ns/1ps
`default_nettype none
`include "ocr_defs.svh"

// Functional notes
// RULE1: The second differential output comes from the first divider when its source bit is 0 and the third when 1, reset 0.
// RULE2: The output kind field selects CMOS on 00 and current-steering differential on 11, resets to 11, and 01 or 10 are never written.
// RULE3: The slew bit gives normal slew on 0 and strong slew on 1 in CMOS mode, reset 0.
// RULE4: The complement leg enable bit turns the CMOS complementary leg on when set, reset off.
// RULE5: Writing 0 to the power-down bit powers the chip down, writing 1 restores it, reset 1.
// RULE6: The first single-ended output runs at 32k until its default bit is set, then takes divider four on select 1 or five on 0; defaults 0 and 1.
// RULE7: Two bits enable channels 3 and 2 of the fourth divider, both reset off.
// RULE8: Reserved bits ignore writes and read back their default values.
module ocr_regs
  import ocr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port from the serial decoder
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Divider and free-run sources
  input wire ocr_sources_t sources,
  // Configuration seen by the analog outputs
  output ocr_diff2_t diff2_cfg,
  output ocr_sediv_t sediv_cfg,
  output logic second_diff_strong_slew,
  output logic second_diff_complement_on,
  output logic chip_powered_down,
  // Routed outputs
  output logic second_diff_clock,
  output logic first_single_ended_output,
  output logic fourth_divider_ch3,
  output logic fourth_divider_ch2
);

  ocr_diff2_t diff2_q;
  ocr_sediv_t sediv_q;
  logic [7:0] diff2_byte;
  logic [7:0] sediv_byte;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic d2_clk_q;
  logic se_out_q;
  logic ch3_q;
  logic ch2_q;
  logic wr_diff2;
  logic wr_sediv;
  logic [1:0] wr_kind;

  assign wr_diff2 = reg_wr && (reg_addr == `OCR_ADDR_DIFF2);
  assign wr_sediv = reg_wr && (reg_addr == `OCR_ADDR_SEDIV);
  assign wr_kind = reg_wdata[`OCR_D2_KIND_HI:`OCR_D2_KIND_LO];

  // Byte images; reserved positions are constants, never stored
  assign diff2_byte = (`OCR_DIFF2_RSVD & ~`OCR_DIFF2_WMASK)
    | ({diff2_q.second_diff_source_select, 1'b0,
        diff2_q.second_diff_output_kind, 2'b00,
        diff2_q.second_diff_cmos_slew,
        diff2_q.second_diff_complement_leg_enable}
       & `OCR_DIFF2_WMASK); // [RULE8]
  assign sediv_byte = (`OCR_SEDIV_RSVD & ~`OCR_SEDIV_WMASK)
    | ({sediv_q.software_chip_powerdown_n, sediv_q.ref_free_run, 1'b0,
        sediv_q.first_single_ended_default,
        sediv_q.first_single_ended_source_select, sediv_q.ref_enable,
        sediv_q.fourth_divider_ch3_enable,
        sediv_q.fourth_divider_ch2_enable}
       & `OCR_SEDIV_WMASK); // [RULE8]

  // Second differential control register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      diff2_q.second_diff_source_select <=
        1'(`OCR_DIFF2_RESET >> `OCR_D2_SRC_BIT); // [RULE1]
      diff2_q.second_diff_output_kind <=
        ocr_kind_t'(`OCR_KIND_CSDIFF); // [RULE2]
      diff2_q.second_diff_cmos_slew <= 1'b0; // [RULE3]
      diff2_q.second_diff_complement_leg_enable <= 1'b0; // [RULE4]
    end else if (wr_diff2) begin
      diff2_q.second_diff_source_select <=
        reg_wdata[`OCR_D2_SRC_BIT]; // [RULE1]
      // A reserved kind code would leave the pad undefined; keep old one
      if (wr_kind == `OCR_KIND_CMOS || wr_kind == `OCR_KIND_CSDIFF) begin
        diff2_q.second_diff_output_kind <= ocr_kind_t'(wr_kind); // [RULE2]
      end
      diff2_q.second_diff_cmos_slew <= reg_wdata[`OCR_D2_SLEW_BIT]; // [RULE3]
      diff2_q.second_diff_complement_leg_enable <=
        reg_wdata[`OCR_D2_COMP_BIT]; // [RULE4]
    end
  end

  // Single-ended and fourth divider control register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sediv_q.software_chip_powerdown_n <= 1'b1; // [RULE5]
      sediv_q.ref_free_run <= 1'b0;
      sediv_q.first_single_ended_default <= 1'b0; // [RULE6]
      sediv_q.first_single_ended_source_select <= 1'b1; // [RULE6]
      sediv_q.ref_enable <= 1'b1;
      sediv_q.fourth_divider_ch3_enable <= 1'b0; // [RULE7]
      sediv_q.fourth_divider_ch2_enable <= 1'b0; // [RULE7]
    end else if (wr_sediv) begin
      sediv_q.software_chip_powerdown_n <=
        reg_wdata[`OCR_SE_PDN_BIT]; // [RULE5]
      sediv_q.ref_free_run <= reg_wdata[`OCR_SE_REFRUN_BIT];
      sediv_q.first_single_ended_default <=
        reg_wdata[`OCR_SE_DFLT_BIT]; // [RULE6]
      sediv_q.first_single_ended_source_select <=
        reg_wdata[`OCR_SE_SRC_BIT]; // [RULE6]
      sediv_q.ref_enable <= reg_wdata[`OCR_SE_REFEN_BIT];
      sediv_q.fourth_divider_ch3_enable <=
        reg_wdata[`OCR_SE_CH3_BIT]; // [RULE7]
      sediv_q.fourth_divider_ch2_enable <=
        reg_wdata[`OCR_SE_CH2_BIT]; // [RULE7]
    end
  end

  // Read port: one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `OCR_ADDR_DIFF2: rdata_q <= diff2_byte; // [RULE8]
          `OCR_ADDR_SEDIV: rdata_q <= sediv_byte; // [RULE8]
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // Output routing, retimed; power-down silences every routed output
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      d2_clk_q <= 1'b0;
      se_out_q <= 1'b0;
      ch3_q <= 1'b0;
      ch2_q <= 1'b0;
    end else if (!sediv_q.software_chip_powerdown_n) begin
      d2_clk_q <= 1'b0; // [RULE5]
      se_out_q <= 1'b0; // [RULE5]
      ch3_q <= 1'b0; // [RULE5]
      ch2_q <= 1'b0; // [RULE5]
    end else begin
      d2_clk_q <= diff2_q.second_diff_source_select
        ? sources.third_output_divider
        : sources.first_output_divider; // [RULE1]
      if (!sediv_q.first_single_ended_default) begin
        se_out_q <= sources.free_run_32k; // [RULE6]
      end else begin
        se_out_q <= sediv_q.first_single_ended_source_select
          ? sources.fourth_output_divider
          : sources.fifth_output_divider; // [RULE6]
      end
      ch3_q <= sources.fourth_output_divider
        & sediv_q.fourth_divider_ch3_enable; // [RULE7]
      ch2_q <= sources.fourth_output_divider
        & sediv_q.fourth_divider_ch2_enable; // [RULE7]
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign diff2_cfg = diff2_q;
  assign sediv_cfg = sediv_q;
  // Slew and complement leg only mean something on a CMOS pad
  assign second_diff_strong_slew = diff2_q.second_diff_cmos_slew
    && (diff2_q.second_diff_output_kind == OCR_CMOS); // [RULE3]
  assign second_diff_complement_on =
    diff2_q.second_diff_complement_leg_enable
    && (diff2_q.second_diff_output_kind == OCR_CMOS); // [RULE4]
  assign chip_powered_down = !sediv_q.software_chip_powerdown_n; // [RULE5]
  assign second_diff_clock = d2_clk_q;
  assign first_single_ended_output = se_out_q;
  assign fourth_divider_ch3 = ch3_q;
  assign fourth_divider_ch2 = ch2_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  src_mux_a: assert property ( // [RULE1]
    sediv_q.software_chip_powerdown_n ##1 sediv_q.software_chip_powerdown_n
    |-> d2_clk_q == ($past(diff2_q.second_diff_source_select)
      ? $past(sources.third_output_divider)
      : $past(sources.first_output_divider)))
    else $error("second diff source mux wrong");
  kind_legal_a: assert property ( // [RULE2]
    diff2_q.second_diff_output_kind == OCR_CMOS
    || diff2_q.second_diff_output_kind == OCR_CURRENT_STEERING)
    else $error("reserved output kind stored");
  kind_written_a: assert property ( // [RULE2]
    wr_diff2 && wr_kind == `OCR_KIND_CMOS
    |=> diff2_q.second_diff_output_kind == OCR_CMOS)
    else $error("cmos kind write lost");
  slew_gate_a: assert property ( // [RULE3]
    wr_diff2 && wr_kind == `OCR_KIND_CMOS && reg_wdata[`OCR_D2_SLEW_BIT]
    |=> second_diff_strong_slew)
    else $error("strong slew not applied");
  comp_leg_a: assert property ( // [RULE4]
    wr_diff2 && wr_kind == `OCR_KIND_CMOS
    |=> second_diff_complement_on == $past(reg_wdata[`OCR_D2_COMP_BIT]))
    else $error("complement leg not applied");
  pd_silence_a: assert property ( // [RULE5]
    wr_sediv && !reg_wdata[`OCR_SE_PDN_BIT]
    |=> chip_powered_down ##1 (!d2_clk_q && !se_out_q && !ch3_q && !ch2_q))
    else $error("power down did not silence outputs");
  se_default_a: assert property ( // [RULE6]
    sediv_q.software_chip_powerdown_n && !sediv_q.first_single_ended_default
    ##1 sediv_q.software_chip_powerdown_n
    |-> se_out_q == $past(sources.free_run_32k))
    else $error("single-ended default not 32k");
  ch_gate_a: assert property ( // [RULE7]
    !sediv_q.fourth_divider_ch3_enable && !sediv_q.fourth_divider_ch2_enable
    |=> !ch3_q && !ch2_q)
    else $error("disabled channel toggled");
  rsvd_read_a: assert property ( // [RULE8]
    reg_rd && reg_addr == `OCR_ADDR_DIFF2
    |=> rvalid_q && ((rdata_q & ~`OCR_DIFF2_WMASK)
      == (`OCR_DIFF2_RSVD & ~`OCR_DIFF2_WMASK)))
    else $error("reserved read value wrong");

  kind_switch_c: cover property (wr_diff2 && wr_kind == `OCR_KIND_CMOS);
  pd_cycle_c: cover property (chip_powered_down ##[1:20] !chip_powered_down);
  se_fourth_c: cover property (
    sediv_q.first_single_ended_default
    && sediv_q.first_single_ended_source_select);

endmodule
`default_nettype wire

// ===== design/ocr_defs.svh
// Offsets, field positions and reset values of the output config pair
`ifndef OCR_DEFS_SVH
`define OCR_DEFS_SVH

`define OCR_ADDR_DIFF2 8'h23
`define OCR_ADDR_SEDIV 8'h24

`define OCR_D2_SRC_BIT 7
`define OCR_D2_KIND_HI 5
`define OCR_D2_KIND_LO 4
`define OCR_D2_SLEW_BIT 1
`define OCR_D2_COMP_BIT 0

`define OCR_SE_PDN_BIT 7
`define OCR_SE_REFRUN_BIT 6
`define OCR_SE_DFLT_BIT 4
`define OCR_SE_SRC_BIT 3
`define OCR_SE_REFEN_BIT 2
`define OCR_SE_CH3_BIT 1
`define OCR_SE_CH2_BIT 0

// Reserved bits read back fixed; writable bits are masked in
`define OCR_DIFF2_WMASK 8'hb3
`define OCR_DIFF2_RSVD 8'h04
`define OCR_SEDIV_WMASK 8'hdf
`define OCR_SEDIV_RSVD 8'h00

`define OCR_DIFF2_RESET 8'h34
`define OCR_SEDIV_RESET 8'h8c

`define OCR_KIND_CMOS 2'h0
`define OCR_KIND_CSDIFF 2'h3

`endif

// ===== design/ocr_pkg.sv
// Types shared by the output config pair
package ocr_pkg;

  typedef enum logic [1:0] {
    OCR_CMOS = 2'h0,
    OCR_RSVD1 = 2'h1,
    OCR_RSVD2 = 2'h2,
    OCR_CURRENT_STEERING = 2'h3
  } ocr_kind_t;

  typedef struct packed {
    logic second_diff_source_select;
    ocr_kind_t second_diff_output_kind;
    logic second_diff_cmos_slew;
    logic second_diff_complement_leg_enable;
  } ocr_diff2_t;

  typedef struct packed {
    logic software_chip_powerdown_n;
    logic ref_free_run;
    logic first_single_ended_default;
    logic first_single_ended_source_select;
    logic ref_enable;
    logic fourth_divider_ch3_enable;
    logic fourth_divider_ch2_enable;
  } ocr_sediv_t;

  typedef struct packed {
    logic first_output_divider;
    logic third_output_divider;
    logic fourth_output_divider;
    logic fifth_output_divider;
    logic free_run_32k;
  } ocr_sources_t;

endpackage

// ===== dv/ocr_host_model.sv
// Host model driving the register port of the output config pair
`timescale 1ns/1ps
`default_nettype none
module ocr_host_model (
  // Clock
  input wire logic clock,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One byte per strobe; the caller picks the byte, so refusal tests
  // can hand in a reserved kind on purpose
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
  endtask

  // Answer is awaited under a bound so a silent port cannot hang the run
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    d = 8'h00;
    ok = 1'b0;
    @(posedge clock);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        ok = 1'b1;
      end else begin
        @(posedge clock);
        #1;
      end
    end
  endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the output config pair
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ocr_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] r;
    logic [1:0] sc;
  } ocr_row_t;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  ocr_sources_t src = '0;
  ocr_diff2_t d2cfg;
  ocr_sediv_t secfg;
  logic reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic slew, comp, pdn, d2, se, ch3, ch2;
  int error_cnt = 0;
  int n_checks = 0;
  // Kinds 01 and 10 must leave the stored kind alone
  ocr_row_t rows [8] = '{'{8'h23, 8'hff, 8'hb7, 2'h0},
    '{8'h23, 8'h03, 8'h07, 2'h3}, '{8'h23, 8'h92, 8'h86, 2'h2},
    '{8'h23, 8'he1, 8'h85, 2'h1}, '{8'h24, 8'hff, 8'hdf, 2'h1},
    '{8'h24, 8'h00, 8'h00, 2'h1}, '{8'h25, 8'hff, 8'h00, 2'h1},
    '{8'h24, 8'h8c, 8'h8c, 2'h1}};

  always #25 clock = ~clock;

  ocr_host_model u_host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  ocr_regs u_dut (.clock(clock), .resetn(resetn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sources(src),
    .diff2_cfg(d2cfg), .sediv_cfg(secfg), .second_diff_strong_slew(slew),
    .second_diff_complement_on(comp), .chip_powered_down(pdn),
    .second_diff_clock(d2), .first_single_ended_output(se),
    .fourth_divider_ch3(ch3), .fourth_divider_ch2(ch2));

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    chk("rvalid", 8'h01, {7'h00, ok});
    chk("rdata", e, d);
  endtask

  // Stored fields must match the byte image of the same register
  task automatic cfgchk(input logic [7:0] a, input logic [7:0] r);
    if (a == 8'h23)
      chk("diff2_cfg", {3'h0, r[7], r[5:4], r[1:0]}, {3'h0, d2cfg});
    else if (a == 8'h24)
      chk("sediv_cfg", {1'h0, r[7:6], r[4:0]}, {1'h0, secfg});
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #1000000;
    error_cnt++;
    $display("[ERR] watchdog expected done seen timeout");
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clock);
    #1;
    chk("pdn_rst", 8'h00, {7'h00, pdn});
    chk("rvalid_rst", 8'h00, {7'h00, reg_rvalid});
    cfgchk(8'h23, 8'h34);
    cfgchk(8'h24, 8'h8c);
    resetn = 1'b1;
    rchk(8'h23, 8'h34);
    rchk(8'h24, 8'h8c);
    rchk(8'h30, 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      u_host.wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].r);
      cfgchk(rows[i].a, rows[i].r);
      chk("slew_comp", {6'h00, rows[i].sc}, {6'h00, slew, comp});
    end
    $display("test table done");
    for (int c = 0; c < 8; c++) begin
      u_host.wr(8'h23, {c[0], 7'h04});
      u_host.wr(8'h24, {3'h4, c[1], c[2], 1'b1, c[1], c[0]});
      for (int v = 0; v < 32; v++) begin
        src = v[4:0];
        repeat (2) @(posedge clock);
        #1;
        chk("d2", {7'h00, c[0] ? v[3] : v[4]}, {7'h00, d2});
        chk("se", {7'h00, c[1] ? (c[2] ? v[2] : v[1]) : v[0]}, {7'h00, se});
        chk("ch", {6'h00, c[1] & v[2], c[0] & v[2]}, {6'h00, ch3, ch2});
      end
    end
    $display("test routing done");
    u_host.wr(8'h24, 8'h1f);
    src = 5'h1f;
    repeat (2) @(posedge clock);
    #1;
    chk("pdn", 8'h01, {7'h00, pdn});
    chk("gated", 8'h00, {4'h0, d2, se, ch3, ch2});
    u_host.wr(8'h24, 8'h9f);
    repeat (2) @(posedge clock);
    #1;
    chk("pdn_off", 8'h00, {7'h00, pdn});
    chk("ungated", 8'h0f, {4'h0, d2, se, ch3, ch2});
    $display("test powerdown done");
    resetn = 1'b0;
    @(posedge clock);
    #1;
    resetn = 1'b1;
    rchk(8'h23, 8'h34);
    rchk(8'h24, 8'h8c);
    cfgchk(8'h23, 8'h34);
    cfgchk(8'h24, 8'h8c);
    $display("test second reset done");
    finish_test();
  end
endmodule
`default_nettype wire
